//--- sje_map.svh
/*
  Constants of the sync jitter eliminator: register offsets, bit fields,
  reset values and counter widths.
  Assumes a 12-bit byte address and 8-bit register data.
*/
// Notes on behaviour
// - Cleaned internal vsync keeps display stable
// - Detect field identity, hand to display
// - Source select: 0 raw pin, 1 cleaned
// - Auto field decide bit: 0 off, 1 on
// - Cleanup enable at control bit 2
// - Cleanup off: display second field only
// - Auto-field off: display second field only
// - Vsync within quarter line snaps to stable
// - Three-bit phase code, hsync to vsync
// - Field flag 1 first-dot, 0 second-dot
`ifndef SJE_MAP_SVH
`define SJE_MAP_SVH

`define SJE_ADDR_W 12
`define SJE_ADDR_CTRL 12'hfe4
`define SJE_ADDR_STAT 12'hfe5
`define SJE_DATA_W 8

`define SJE_CTRL_SRC_SEL 4
`define SJE_CTRL_AUTO_FLD 3
`define SJE_CTRL_CLEAN_EN 2
`define SJE_CTRL_RST 1'h0

`define SJE_STAT_FIELD 7
`define SJE_STAT_PH_MSB 2
`define SJE_STAT_PH_LSB 0
`define SJE_STAT_GAP 4'h0
`define SJE_RDATA_RST 8'h00

`define SJE_CNT_W 12
`define SJE_CNT_MAX 12'hfff
`define SJE_CNT_ONE 12'h001
`define SJE_DLY_W 13
`define SJE_DLY_ONE 13'h0001
`define SJE_PH_W 3
`define SJE_PHASES 8
`define SJE_QTR_SHIFT 2

`define SJE_SYNC_LINES 2
`define SJE_IDLE_LVL 2'h3
`define SJE_HS_BIT 0
`define SJE_VS_BIT 1

`endif

//--- sje_pkg.sv
/*
  Types of the sync jitter eliminator: state records and snap states.
  Assumes sje_map.svh is reachable on the include path.
*/
`default_nettype none
`include "sje_map.svh"

package sje_pkg;

  typedef enum logic [0:0] {SNAP_IDLE, SNAP_WAIT} sje_snap_t;

  typedef struct packed {
    logic src_sel;
    logic auto_fld;
    logic clean_en;
    logic [`SJE_CNT_W-1:0] hcnt;
    logic [`SJE_CNT_W-1:0] hper;
    logic [`SJE_PH_W-1:0] phase;
    logic field;
    sje_snap_t snap;
    logic [`SJE_DLY_W-1:0] dly;
    logic clean_n;
    logic vs_n;
    logic show;
    logic [`SJE_DATA_W-1:0] rdata;
  } sje_state_t;

  typedef struct packed {
    logic [`SJE_SYNC_LINES-1:0] s1;
    logic [`SJE_SYNC_LINES-1:0] s2;
    logic [`SJE_SYNC_LINES-1:0] s3;
    logic [`SJE_SYNC_LINES-1:0] lvl;
    logic [`SJE_SYNC_LINES-1:0] fall;
    logic [`SJE_SYNC_LINES-1:0] rise;
  } sje_sync_state_t;

endpackage : sje_pkg

`default_nettype wire

//--- sje_sync_if.sv
/*
  Carrier of the synchronised sync lines from the input stage to the core.
  Assumes one clock domain; all signals are registered by the source.
*/
`timescale 1ns/1ps
`default_nettype none

interface sje_sync_if;
  logic hs_lvl;
  logic vs_lvl;
  logic hs_fall;
  logic vs_fall;
  logic vs_rise;

  modport src (output hs_lvl, vs_lvl, hs_fall, vs_fall, vs_rise);
  modport dst (input hs_lvl, vs_lvl, hs_fall, vs_fall, vs_rise);
endinterface : sje_sync_if

`default_nettype wire

//--- sje_sync.sv
/*
  Three-stage input synchroniser and edge finder for the sync pins.
  Assumes asynchronous active-low sync pins idling high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sje_map.svh"

module sje_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sync pins, active low
  input wire logic hs_n_i,
  input wire logic vs_n_i,
  // Cleaned lines toward the core
  sje_sync_if.src sy
);

  localparam sje_pkg::sje_sync_state_t RST_ST = '{
    s1: `SJE_IDLE_LVL, s2: `SJE_IDLE_LVL, s3: `SJE_IDLE_LVL,
    lvl: `SJE_IDLE_LVL, fall: '0, rise: '0};

  sje_pkg::sje_sync_state_t st_r;
  sje_pkg::sje_sync_state_t st_nxt;

  // Stage one feeds stage two only; a level counts once two and three agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = {vs_n_i, hs_n_i};
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < `SJE_SYNC_LINES; i++) begin
      st_nxt.fall[i] = 1'b0;
      st_nxt.rise[i] = 1'b0;
      if (st_r.s2[i] == st_r.s3[i] && st_r.s3[i] != st_r.lvl[i]) begin
        st_nxt.lvl[i] = st_r.s3[i];
        st_nxt.fall[i] = !st_r.s3[i];
        st_nxt.rise[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sy.hs_lvl = st_r.lvl[`SJE_HS_BIT];
  assign sy.vs_lvl = st_r.lvl[`SJE_VS_BIT];
  assign sy.hs_fall = st_r.fall[`SJE_HS_BIT];
  assign sy.vs_fall = st_r.fall[`SJE_VS_BIT];
  assign sy.vs_rise = st_r.rise[`SJE_VS_BIT];

endmodule : sje_sync

`default_nettype wire

//--- sje_top.sv
/*
  Sync jitter eliminator: measures the line period, finds the phase of the
  vertical sync against the horizontal sync, snaps the internal vertical
  sync to a stable point and derives the display field.
  Assumes a 10 MHz clock, asynchronous active-low sync pins and a plain
  register port with read data one cycle after the read strobe.
*/
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sje_map.svh"

module sje_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [`SJE_ADDR_W-1:0] addr_i,
  input wire logic [`SJE_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`SJE_DATA_W-1:0] rdata_o,
  // Video source sync pins, active low
  input wire logic horizontal_sync_in_n_i,
  input wire logic vertical_sync_in_n_i,
  // Toward the display logic
  output logic vsync_display_n_o,
  output logic field_identity_flag_o,
  output logic osd_show_o
);

  localparam sje_pkg::sje_state_t RST_ST = '{
    src_sel: `SJE_CTRL_RST, auto_fld: `SJE_CTRL_RST,
    clean_en: `SJE_CTRL_RST,
    hcnt: '0, hper: '0, phase: '0, field: 1'b0,
    snap: sje_pkg::SNAP_IDLE, dly: '0, clean_n: 1'b1, vs_n: 1'b1,
    show: 1'b1, rdata: `SJE_RDATA_RST};

  sje_sync_if sy ();

  sje_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .hs_n_i(horizontal_sync_in_n_i),
    .vs_n_i(vertical_sync_in_n_i),
    .sy(sy)
  );

  sje_pkg::sje_state_t st_r;
  sje_pkg::sje_state_t st_nxt;

  // Quarter of the measured line
  function automatic logic [`SJE_CNT_W-1:0] sje_qtr(
      input logic [`SJE_CNT_W-1:0] per);
    sje_qtr = per >> `SJE_QTR_SHIFT;
  endfunction : sje_qtr

  // Vsync edge lies within a quarter line of an hsync edge
  function automatic logic sje_in_win(input logic [`SJE_CNT_W-1:0] pos,
      input logic [`SJE_CNT_W-1:0] per);
    logic [`SJE_CNT_W-1:0] q;
    q = sje_qtr(per);
    sje_in_win = (per != '0) && ((pos < q) || (pos >= per - q));
  endfunction : sje_in_win

  // Phase code: which eighth of the line the vsync edge fell in
  function automatic logic [`SJE_PH_W-1:0] sje_phase(
      input logic [`SJE_CNT_W-1:0] pos, input logic [`SJE_CNT_W-1:0] per);
    logic [`SJE_CNT_W+2:0] lhs;
    logic [`SJE_CNT_W+2:0] rhs;
    sje_phase = '0;
    lhs = {pos, 3'h0};
    for (int k = 1; k < `SJE_PHASES; k++) begin
      rhs = (`SJE_CNT_W+3)'(per) * (`SJE_CNT_W+3)'(k);
      if (per != '0 && lhs >= rhs) begin
        sje_phase = `SJE_PH_W'(k);
      end
    end
  endfunction : sje_phase

  logic win;
  logic [`SJE_CNT_W-1:0] qtr;
  logic [`SJE_DATA_W-1:0] stat_word;

  assign win = sje_in_win(st_r.hcnt, st_r.hper);
  assign qtr = sje_qtr(st_r.hper);
  assign stat_word = {st_r.field, `SJE_STAT_GAP, st_r.phase};

  always_comb begin
    st_nxt = st_r;
    if (wr_i && addr_i == `SJE_ADDR_CTRL) begin
      st_nxt.src_sel = wdata_i[`SJE_CTRL_SRC_SEL];
      st_nxt.auto_fld = wdata_i[`SJE_CTRL_AUTO_FLD];
      st_nxt.clean_en = wdata_i[`SJE_CTRL_CLEAN_EN];
    end
    // Control is write-only, so only the status answers a read
    st_nxt.rdata = `SJE_RDATA_RST;
    if (rd_i && addr_i == `SJE_ADDR_STAT) begin
      st_nxt.rdata = stat_word;
    end
    // Line period, saturating so a lost hsync cannot wrap the count
    if (sy.hs_fall) begin
      st_nxt.hper = st_r.hcnt + `SJE_CNT_ONE;
      st_nxt.hcnt = '0;
    end else if (st_r.hcnt != `SJE_CNT_MAX) begin
      st_nxt.hcnt = st_r.hcnt + `SJE_CNT_ONE;
    end
    // refresh per vsync; field from window
    if (sy.vs_fall) begin
      st_nxt.phase = sje_phase(st_r.hcnt, st_r.hper);
      st_nxt.field = win;
    end
    // snap vsync to a quarter line after hsync
    case (st_r.snap)
      sje_pkg::SNAP_IDLE: begin
        if (sy.vs_fall) begin
          if (st_r.clean_en && win) begin
            st_nxt.snap = sje_pkg::SNAP_WAIT;
            if (st_r.hcnt < qtr) begin
              st_nxt.dly = `SJE_DLY_W'(qtr - st_r.hcnt);
            end else begin
              st_nxt.dly = `SJE_DLY_W'(st_r.hper - st_r.hcnt)
                + `SJE_DLY_W'(qtr);
            end
          end else begin
            st_nxt.clean_n = 1'b0;
          end
        end
      end
      sje_pkg::SNAP_WAIT: begin
        if (st_r.dly <= `SJE_DLY_ONE) begin
          st_nxt.clean_n = 1'b0;
          st_nxt.snap = sje_pkg::SNAP_IDLE;
        end else begin
          st_nxt.dly = st_r.dly - `SJE_DLY_ONE;
        end
      end
      default: begin
        st_nxt.snap = sje_pkg::SNAP_IDLE;
      end
    endcase
    if (sy.vs_rise) begin
      st_nxt.clean_n = 1'b1;
    end
    // disabled cleanup passes the pin through
    if (!st_r.clean_en) begin
      st_nxt.clean_n = sy.vs_lvl;
      st_nxt.snap = sje_pkg::SNAP_IDLE;
    end
    st_nxt.vs_n = st_r.src_sel ? st_nxt.clean_n : sy.vs_lvl;
    // second field only unless both bits set
    st_nxt.show = (st_r.clean_en && st_r.auto_fld) ? 1'b1 : !st_nxt.field;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= RST_ST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign vsync_display_n_o = st_r.vs_n;
  assign field_identity_flag_o = st_r.field;
  assign osd_show_o = st_r.show;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_status_read: assert property (
    rd_i && addr_i == `SJE_ADDR_STAT |=> rdata_o == $past(stat_word))
    else $error("status read data wrong");

  chk_status_fields: assert property (
    rd_i && addr_i == `SJE_ADDR_STAT
    |=> rdata_o[`SJE_STAT_FIELD] == $past(st_r.field)
      && rdata_o[`SJE_STAT_FIELD-1:`SJE_STAT_PH_MSB+1] == `SJE_STAT_GAP
      && rdata_o[`SJE_STAT_PH_MSB:`SJE_STAT_PH_LSB] == $past(st_r.phase))
    else $error("status byte layout wrong");

  chk_unmapped_zero: assert property (
    (rd_i && addr_i != `SJE_ADDR_STAT) || !rd_i |=> rdata_o == '0)
    else $error("unmapped or idle read not zero");

  chk_ctrl_write: assert property (
    wr_i && addr_i == `SJE_ADDR_CTRL
    |=> st_r.clean_en == $past(wdata_i[`SJE_CTRL_CLEAN_EN])
      && st_r.auto_fld == $past(wdata_i[`SJE_CTRL_AUTO_FLD])
      && st_r.src_sel == $past(wdata_i[`SJE_CTRL_SRC_SEL]))
    else $error("control bits not stored");

  chk_ctrl_hold: assert property (
    !(wr_i && addr_i == `SJE_ADDR_CTRL)
    |=> $stable(st_r.clean_en) && $stable(st_r.auto_fld)
      && $stable(st_r.src_sel))
    else $error("control bits changed without a write");

  chk_raw_route: assert property (
    !st_r.src_sel ##1 !$past(wr_i) |-> vsync_display_n_o == $past(sy.vs_lvl))
    else $error("raw vsync not routed");

  chk_clean_route: assert property (
    st_r.src_sel |=> vsync_display_n_o == st_r.clean_n)
    else $error("cleaned vsync not routed");

  chk_off_pass: assert property (
    !st_r.clean_en ##1 !$past(wr_i) |-> st_r.clean_n == $past(sy.vs_lvl)
      && st_r.snap == sje_pkg::SNAP_IDLE)
    else $error("disabled cleanup not transparent");

  chk_clean_rise: assert property (
    st_r.clean_en && sy.vs_rise |=> st_r.clean_n)
    else $error("cleaned vsync did not rise");

  chk_second_only: assert property (
    !$past(st_r.clean_en) || !$past(st_r.auto_fld)
    |-> osd_show_o == !st_r.field)
    else $error("display not limited to second field");

  chk_second_shown: assert property (
    !field_identity_flag_o |-> osd_show_o)
    else $error("second field blanked");

  chk_both_fields: assert property (
    $past(st_r.clean_en) && $past(st_r.auto_fld) |-> osd_show_o)
    else $error("display blanked with auto field on");

  chk_phase_hold: assert property (
    !sy.vs_fall |=> $stable(st_r.phase) && $stable(st_r.field))
    else $error("status changed without vsync");

  chk_field_update: assert property (
    sy.vs_fall |=> st_r.field == $past(win)
      && st_r.phase == $past(sje_phase(st_r.hcnt, st_r.hper)))
    else $error("field or phase not taken at vsync");

  chk_field_near: assert property (
    sy.vs_fall && st_r.hper != '0
      && (st_r.hcnt < qtr || st_r.hcnt >= st_r.hper - qtr)
    |=> st_r.field)
    else $error("vsync near hsync not first field");

  chk_field_far: assert property (
    sy.vs_fall && st_r.hcnt >= qtr && st_r.hcnt < st_r.hper - qtr
    |=> !st_r.field)
    else $error("mid-line vsync not second field");

  chk_line_period: assert property (
    sy.hs_fall |=> st_r.hper == $past(st_r.hcnt) + `SJE_CNT_ONE
      && st_r.hcnt == '0)
    else $error("line period not measured");

  chk_line_count: assert property (
    !sy.hs_fall |=> st_r.hcnt == ($past(st_r.hcnt) == `SJE_CNT_MAX
      ? `SJE_CNT_MAX : $past(st_r.hcnt) + `SJE_CNT_ONE))
    else $error("line counter wrong");

  chk_snap_load: assert property (
    st_r.clean_en && st_r.snap == sje_pkg::SNAP_IDLE && sy.vs_fall && win
    |=> st_r.snap == sje_pkg::SNAP_WAIT
      && st_r.clean_n == $past(st_r.clean_n))
    else $error("vsync in window not held back");

  chk_snap_miss: assert property (
    st_r.clean_en && st_r.snap == sje_pkg::SNAP_IDLE && sy.vs_fall && !win
    |=> !st_r.clean_n && st_r.snap == sje_pkg::SNAP_IDLE)
    else $error("vsync outside window delayed");

  chk_snap_count: assert property (
    st_r.clean_en && st_r.snap == sje_pkg::SNAP_WAIT
      && st_r.dly > `SJE_DLY_ONE
    |=> st_r.dly == $past(st_r.dly) - `SJE_DLY_ONE)
    else $error("snap wait not counting down");

  chk_snap_fall: assert property (
    st_r.clean_en && st_r.snap == sje_pkg::SNAP_WAIT
      && st_r.dly <= `SJE_DLY_ONE && !sy.vs_rise && !wr_i
    |=> !st_r.clean_n && st_r.snap == sje_pkg::SNAP_IDLE)
    else $error("snapped vsync missed its point");

  cov_snap: cover property (
    st_r.snap == sje_pkg::SNAP_WAIT ##1 st_r.snap == sje_pkg::SNAP_IDLE);
  cov_first_field: cover property (sy.vs_fall ##1 st_r.field);
  cov_both_fields: cover property (st_r.clean_en && st_r.auto_fld && st_r.src_sel);
  cov_status_read: cover property (rd_i && addr_i == `SJE_ADDR_STAT);
  cov_snap_miss: cover property (st_r.clean_en && sy.vs_fall && !win);

endmodule : sje_top

`default_nettype wire

//--- sje_video_src.sv
/*
  Video source model: free-running hsync, one vsync per frame.
  Assumes the bench sets the vsync offset; it is taken once a frame.
*/
`timescale 1ns/1ps
`default_nettype none

module sje_video_src #(
  parameter int LINE = 64,
  parameter int FRAME = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Vsync fall position within its line
  input wire logic [11:0] off_i,
  // Sync pins, active low
  output logic hs_n_o,
  output logic vs_n_o
);
  int pos;
  int ln;
  int off;

  // Offset taken mid-frame would tear the vsync pulse
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pos <= 0;
      ln <= 3;
      off <= 28;
    end else begin
      pos <= (pos == LINE - 1) ? 0 : pos + 1;
      if (pos == LINE - 1)
        ln <= (ln == FRAME - 1) ? 0 : ln + 1;
      if (ln == 3)
        off <= int'(off_i);
    end
  end

  // Idle high in reset so the core sees no false hsync edge
  assign hs_n_o = !(rst_n_i && pos < 4);
  assign vs_n_o = !((ln == 0 && pos >= off) || ln == 1 ||
                    (ln == 2 && pos < off));
endmodule : sje_video_src

`default_nettype wire

//--- sync_jitter_eliminator_test.sv
/*
  Bench of the sync jitter eliminator: reset, phase sweep, mode table.
  Assumes sje_map.svh on the include path and a 64-clock line.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sje_map.svh"

module sync_jitter_eliminator_test;
  logic clk;
  logic rst_n;
  logic [`SJE_ADDR_W-1:0] addr;
  logic [`SJE_DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [`SJE_DATA_W-1:0] rdata;
  logic hs_n;
  logic vs_n;
  logic vdisp_n;
  logic fld;
  logic show;
  logic [11:0] off;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  sje_top sje_top_inst (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .horizontal_sync_in_n_i(hs_n), .vertical_sync_in_n_i(vs_n),
    .vsync_display_n_o(vdisp_n), .field_identity_flag_o(fld),
    .osd_show_o(show));

  sje_video_src sje_video_src_inst (.clk_i(clk), .rst_n_i(rst_n),
    .off_i(off), .hs_n_o(hs_n), .vs_n_o(vs_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h want %h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd_reg

  task automatic t_reset();
    chk(vdisp_n, 1'b1);
    chk(show, 1'b1);
    chk(fld, 1'b0);
    rd_reg(`SJE_ADDR_CTRL, 8'h00);
    @(negedge clk);
    chk(rdata, 8'h00);
  endtask : t_reset

  // Offsets sit mid-eighth so sync latency cannot shift the code
  task automatic t_sweep();
    logic f;
    wr_reg(`SJE_ADDR_CTRL, 8'h1c);
    wr_reg(12'hfe6, 8'h00);
    for (int k = 0; k < 8; k++) begin
      f = (k < 2 || k > 5);
      off <= 12'(8 * k + 4);
      repeat (2) @(negedge vs_n);
      repeat (10) @(negedge clk);
      rd_reg(`SJE_ADDR_STAT, {f, 4'h0, 3'(k)});
      chk(fld, f);
      chk(show, 1'b1);
    end
  endtask : t_sweep

  task automatic t_mode(input logic [7:0] c, input logic [11:0] o,
                        input logic s, input int d);
    int n;
    wr_reg(`SJE_ADDR_CTRL, c);
    off <= o;
    repeat (2) @(negedge vs_n);
    n = 0;
    while (vdisp_n !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n >= d + 2 && n <= d + 7), 8'h01);
    repeat (8) @(negedge clk);
    chk(show, s);
  endtask : t_mode

  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    rst_n = 1'b0;
    addr = 12'h000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    off = 12'h01c;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset();
    t_sweep();
    t_mode(8'h1c, 12'h004, 1'b1, 12);
    t_mode(8'h1c, 12'h03c, 1'b1, 20);
    t_mode(8'h1c, 12'h01c, 1'b1, 0);
    t_mode(8'h0c, 12'h004, 1'b1, 0);
    t_mode(8'h10, 12'h004, 1'b0, 0);
    t_mode(8'h04, 12'h004, 1'b0, 0);
    t_mode(8'h04, 12'h01c, 1'b1, 0);
    t_mode(8'h00, 12'h004, 1'b0, 0);
    end_sim();
  end
endmodule : sync_jitter_eliminator_test

`default_nettype wire
